// ---- hw/frr_defines.vh ----
`ifndef FRR_DEFINES_VH
`define FRR_DEFINES_VH

// Register offsets (byte addresses on the plain 8-bit port)
`define FRR_ADDR_W 8
`define FRR_OFS_REG_READOUT 8'h2C
`define FRR_OFS_PEAKS 8'h2D
`define FRR_OFS_GAIN_STATE 8'h2E
`define FRR_OFS_CS_CONTROL 8'h2F
`define FRR_OFS_CS_READOUT 8'h30
`define FRR_OFS_REG_MODE 8'h40
`define FRR_OFS_IRQ_STATUS 8'h41
`define FRR_OFS_IRQ_MASK 8'h42

// Field positions
`define FRR_CODE_HI 7
`define FRR_CODE_LO 4
`define FRR_PM_HI 3
`define FRR_PM_LO 0
`define FRR_ILIM_BIT 0
`define FRR_TRIM_HI 7
`define FRR_TRIM_LO 3
`define FRR_GAIN_HI 2
`define FRR_GAIN_LO 0
`define FRR_CAL_END_BIT 2
`define FRR_CAL_ERR_BIT 1
`define FRR_MODE_SEL_BIT 7

// Interrupt status bits
`define FRR_IRQ_CAL_END 0
`define FRR_IRQ_CAL_ERR 1
`define FRR_IRQ_ILIM 2
`define FRR_IRQ_ADJ_DONE 3
`define FRR_IRQ_W 4

// Reset values
`define FRR_RST_CS_CONTROL 8'h00
`define FRR_RST_REG_MODE 8'h00
`define FRR_RST_CODE 4'h0
`define FRR_RST_IRQ 4'h0

// Gain select codes
`define FRR_GAIN_2P8 3'h0
`define FRR_GAIN_6P5 3'h1
`define FRR_GAIN_1P1 3'h2
`define FRR_GAIN_0P5 3'h4
`define FRR_GAIN_0P35 3'h6

`endif

// ---- hw/frr_readout_regs.v ----
// How it works
// [RULE1] Regulator code bits 7:4 show adjust result
// [RULE2] Code 1111 is top voltage, 0.1V steps
// [RULE3] Bit 0 flags regulator current limit
// [RULE4] Amplitude peak in 7:4, held till cleared
// [RULE5] Phase peak in 3:0, held till cleared
// [RULE6] Peak codes form rising logarithmic threshold scale
// [RULE7] Amplitude total gain cut in bits 7:4
// [RULE8] Phase total gain cut in bits 3:0
// [RULE9] Control bits 7:3 hold manual trim
// [RULE10] Zero manual trim selects automatic calibration
// [RULE11] Three-bit sensor gain; codes 3, 5 and 7 unused
// [RULE12] Readout bits 7:3 show trim in effect
// [RULE13] Readout bit 2 set when calibration ends
// [RULE14] Readout bit 1 set on calibration error
// [RULE15] Mode bit picks adjust or software code
// [RULE16] Reserved bits zero; read-only writes ignored
// [RULE17] Clear command zeroes both peaks together
`include "frr_defines.vh"

module frr_readout_regs #(
    parameter CODE_W = 4,
    parameter TRIM_W = 5
) (
    input wire clock_in,
    input wire rst_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire adjust_done_in,
    input wire [CODE_W-1:0] adjust_code_in,
    input wire ilim_in,
    input wire rx_start_in,
    input wire peak_clear_in,
    input wire [CODE_W-1:0] amp_level_in,
    input wire [CODE_W-1:0] phase_level_in,
    input wire [CODE_W-1:0] amp_gain_cut_in,
    input wire [CODE_W-1:0] phase_gain_cut_in,
    input wire cal_done_in,
    input wire cal_fail_in,
    input wire [TRIM_W-1:0] auto_trim_in,
    output reg [CODE_W-1:0] reg_code_out,
    output reg [TRIM_W-1:0] trim_out,
    output reg auto_cal_out,
    output reg [2:0] sense_gain_out,
    output reg irq_out
);

////////////////////////////////////////////////////////////////////////
// Captured front-end status
reg [CODE_W-1:0] adj_code_ff;
reg [CODE_W-1:0] nxt_adj_code;
reg ilim_ff;
reg ilim_prev_ff;
reg [CODE_W-1:0] amp_peak_ff;
reg [CODE_W-1:0] nxt_amp_peak;
reg [CODE_W-1:0] phase_peak_ff;
reg [CODE_W-1:0] nxt_phase_peak;
reg [CODE_W-1:0] amp_cut_ff;
reg [CODE_W-1:0] phase_cut_ff;
reg [TRIM_W-1:0] cal_val_ff;
reg [TRIM_W-1:0] nxt_cal_val;
reg cal_end_ff;
reg nxt_cal_end;
reg cal_err_ff;
reg nxt_cal_err;

// Software-written registers
reg [7:0] cs_ctrl_ff;
reg [7:0] nxt_cs_ctrl;
reg [7:0] reg_mode_ff;
reg [7:0] nxt_reg_mode;
reg [`FRR_IRQ_W-1:0] irq_mask_ff;
reg [`FRR_IRQ_W-1:0] nxt_irq_mask;
reg [`FRR_IRQ_W-1:0] irq_stat_ff;
wire [`FRR_IRQ_W-1:0] nxt_irq_stat;
reg [7:0] nxt_rdata;

////////////////////////////////////////////////////////////////////////
// Address decode and derived fields
wire wr_cs_ctrl = wr_in && (addr_in == `FRR_OFS_CS_CONTROL);
wire wr_reg_mode = wr_in && (addr_in == `FRR_OFS_REG_MODE);
wire wr_irq_mask = wr_in && (addr_in == `FRR_OFS_IRQ_MASK);
wire wr_irq = wr_in && (addr_in == `FRR_OFS_IRQ_STATUS);

wire [TRIM_W-1:0] manual_trim = cs_ctrl_ff[`FRR_TRIM_HI:`FRR_TRIM_LO];
wire use_auto = (manual_trim == {TRIM_W{1'b0}}); // [RULE10]
wire sw_mode = reg_mode_ff[`FRR_MODE_SEL_BIT];
wire [CODE_W-1:0] sw_code = reg_mode_ff[6:3];
// Code is a typical voltage index only; analog side decodes mode-specific level
wire [CODE_W-1:0] eff_code = sw_mode ? sw_code : adj_code_ff; // [RULE15] [RULE2]
wire [TRIM_W-1:0] eff_trim = use_auto ? cal_val_ff : manual_trim; // [RULE10] [RULE12]
wire peak_restart = peak_clear_in || rx_start_in;
wire [`FRR_IRQ_W-1:0] irq_events;
wire [`FRR_IRQ_W-1:0] irq_w1c;

////////////////////////////////////////////////////////////////////////
// Next values of the captured status
always @* begin
    nxt_adj_code = adj_code_ff;
    if (adjust_done_in) begin
        nxt_adj_code = adjust_code_in; // [RULE1]
    end
end

// Clear and new reception both restart the peak search
always @* begin
    nxt_amp_peak = amp_peak_ff;
    if (peak_restart) begin
        nxt_amp_peak = {CODE_W{1'b0}}; // [RULE17] [RULE4]
    end else if (amp_level_in > amp_peak_ff) begin
        // Codes are monotonic thresholds so the max is the peak
        nxt_amp_peak = amp_level_in; // [RULE4] [RULE6]
    end
end

always @* begin
    nxt_phase_peak = phase_peak_ff;
    if (peak_restart) begin
        nxt_phase_peak = {CODE_W{1'b0}}; // [RULE17] [RULE5]
    end else if (phase_level_in > phase_peak_ff) begin
        nxt_phase_peak = phase_level_in; // [RULE5] [RULE6]
    end
end

// Result and flags stay until the next calibration finishes
always @* begin
    nxt_cal_val = cal_val_ff;
    nxt_cal_end = cal_end_ff;
    nxt_cal_err = cal_err_ff;
    if (cal_done_in) begin
        nxt_cal_val = auto_trim_in;
        nxt_cal_end = 1'b1; // [RULE13]
        nxt_cal_err = cal_fail_in; // [RULE14]
    end
end

////////////////////////////////////////////////////////////////////////
// Status capture, one register per process
always @(posedge clock_in) begin
    if (rst_in) begin
        adj_code_ff <= `FRR_RST_CODE;
    end else begin
        adj_code_ff <= nxt_adj_code;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        ilim_ff <= 1'b0;
    end else begin
        ilim_ff <= ilim_in; // [RULE3]
    end
end

// Resets low like the idle pin, so no false edge follows reset
always @(posedge clock_in) begin
    if (rst_in) begin
        ilim_prev_ff <= 1'b0;
    end else begin
        ilim_prev_ff <= ilim_ff;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        amp_peak_ff <= {CODE_W{1'b0}};
    end else begin
        amp_peak_ff <= nxt_amp_peak;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        phase_peak_ff <= {CODE_W{1'b0}};
    end else begin
        phase_peak_ff <= nxt_phase_peak;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        amp_cut_ff <= {CODE_W{1'b0}};
    end else begin
        amp_cut_ff <= amp_gain_cut_in; // [RULE7]
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        phase_cut_ff <= {CODE_W{1'b0}};
    end else begin
        phase_cut_ff <= phase_gain_cut_in; // [RULE8]
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        cal_val_ff <= {TRIM_W{1'b0}};
    end else begin
        cal_val_ff <= nxt_cal_val;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        cal_end_ff <= 1'b0;
    end else begin
        cal_end_ff <= nxt_cal_end;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        cal_err_ff <= 1'b0;
    end else begin
        cal_err_ff <= nxt_cal_err;
    end
end

////////////////////////////////////////////////////////////////////////
// Writable registers; read-only offsets have no write path
always @* begin
    nxt_cs_ctrl = cs_ctrl_ff;
    if (wr_cs_ctrl) begin
        nxt_cs_ctrl = wdata_in; // [RULE9] [RULE11]
    end
end

// Low three bits are not stored so they always read back as zero
always @* begin
    nxt_reg_mode = reg_mode_ff;
    if (wr_reg_mode) begin
        nxt_reg_mode = {wdata_in[7:3], 3'h0}; // [RULE15]
    end
end

always @* begin
    nxt_irq_mask = irq_mask_ff;
    if (wr_irq_mask) begin
        nxt_irq_mask = wdata_in[`FRR_IRQ_W-1:0];
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        cs_ctrl_ff <= `FRR_RST_CS_CONTROL;
    end else begin
        cs_ctrl_ff <= nxt_cs_ctrl; // [RULE16]
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        reg_mode_ff <= `FRR_RST_REG_MODE;
    end else begin
        reg_mode_ff <= nxt_reg_mode;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        irq_mask_ff <= `FRR_RST_IRQ;
    end else begin
        irq_mask_ff <= nxt_irq_mask;
    end
end

////////////////////////////////////////////////////////////////////////
// Sticky interrupts: a new event wins over a same-cycle write-one clear
assign irq_events[`FRR_IRQ_CAL_END] = cal_done_in;
assign irq_events[`FRR_IRQ_CAL_ERR] = cal_done_in && cal_fail_in;
assign irq_events[`FRR_IRQ_ILIM] = ilim_ff && !ilim_prev_ff;
assign irq_events[`FRR_IRQ_ADJ_DONE] = adjust_done_in;
assign irq_w1c = wr_irq ? wdata_in[`FRR_IRQ_W-1:0] : {`FRR_IRQ_W{1'b0}};

genvar gi;
generate
    for (gi = 0; gi < `FRR_IRQ_W; gi = gi + 1) begin : g_irq
        assign nxt_irq_stat[gi] = irq_events[gi] | (irq_stat_ff[gi] & ~irq_w1c[gi]);
    end
endgenerate

always @(posedge clock_in) begin
    if (rst_in) begin
        irq_stat_ff <= `FRR_RST_IRQ;
    end else begin
        irq_stat_ff <= nxt_irq_stat;
    end
end

////////////////////////////////////////////////////////////////////////
// Read mux; unmapped and idle cycles return zero
always @* begin
    nxt_rdata = 8'h00;
    if (rd_in) begin
        case (addr_in)
            `FRR_OFS_REG_READOUT: nxt_rdata = {eff_code, 3'h0, ilim_ff}; // [RULE1] [RULE3] [RULE16]
            `FRR_OFS_PEAKS: nxt_rdata = {amp_peak_ff, phase_peak_ff}; // [RULE4] [RULE5]
            `FRR_OFS_GAIN_STATE: nxt_rdata = {amp_cut_ff, phase_cut_ff}; // [RULE7] [RULE8]
            `FRR_OFS_CS_CONTROL: nxt_rdata = cs_ctrl_ff;
            `FRR_OFS_CS_READOUT: nxt_rdata = {eff_trim, cal_end_ff, cal_err_ff, 1'b0}; // [RULE12] [RULE16]
            `FRR_OFS_REG_MODE: nxt_rdata = reg_mode_ff;
            `FRR_OFS_IRQ_STATUS: nxt_rdata = {4'h0, irq_stat_ff};
            `FRR_OFS_IRQ_MASK: nxt_rdata = {4'h0, irq_mask_ff};
            default: nxt_rdata = 8'h00;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// Registered outputs
always @(posedge clock_in) begin
    if (rst_in) begin
        rdata_out <= 8'h00;
    end else begin
        rdata_out <= nxt_rdata;
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        reg_code_out <= `FRR_RST_CODE;
    end else begin
        reg_code_out <= eff_code; // [RULE15]
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        trim_out <= {TRIM_W{1'b0}};
    end else begin
        trim_out <= eff_trim; // [RULE12]
    end
end

// Reset trim field is zero, so automatic calibration is in force
always @(posedge clock_in) begin
    if (rst_in) begin
        auto_cal_out <= 1'b1;
    end else begin
        auto_cal_out <= use_auto; // [RULE10]
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        sense_gain_out <= 3'h0;
    end else begin
        sense_gain_out <= cs_ctrl_ff[`FRR_GAIN_HI:`FRR_GAIN_LO]; // [RULE11]
    end
end

always @(posedge clock_in) begin
    if (rst_in) begin
        irq_out <= 1'b0;
    end else begin
        irq_out <= |(irq_stat_ff & irq_mask_ff);
    end
end

endmodule

// ---- sim/frr_readout_assertions.sv ----
module frr_readout_checker #(parameter CODE_W = 4, parameter TRIM_W = 5) (
    input wire clock_in, rst_in, wr_in, rd_in, ilim_in, peak_clear_in, auto_cal_out,
    input wire [7:0] addr_in, wdata_in, rdata_out,
    input wire [CODE_W-1:0] amp_level_in, phase_level_in, amp_gain_cut_in, phase_gain_cut_in, reg_code_out,
    input wire [TRIM_W-1:0] trim_out,
    input wire [2:0] sense_gain_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////
    // Read data must be zero in the cycle after an idle cycle or a read above 0x42
    chk_idle_zero: assert property (!rd_in || addr_in > 8'h42 |=> rdata_out == 8'h00)
        else $error("idle read data");
    chk_ro_flags: assert property (rd_in && addr_in == 8'h2C && !$past(rst_in)
        |=> rdata_out[3:0] == {3'h0, $past(ilim_in, 2)}) else $error("limit flag");
    chk_gain_cut: assert property (rd_in && addr_in == 8'h2E && !$past(rst_in)
        |=> rdata_out == {$past(amp_gain_cut_in, 2), $past(phase_gain_cut_in, 2)}) else $error("gain cut");
    chk_peak_clear: assert property (peak_clear_in ##1 (rd_in && addr_in == 8'h2D
        && {amp_level_in, phase_level_in} == 8'h00) |=> rdata_out == 8'h00) else $error("peak clear");
    chk_sense_gain: assert property (wr_in && addr_in == 8'h2F
        |-> ##2 {sense_gain_out, auto_cal_out} == {$past(wdata_in[2:0], 2), $past(wdata_in[7:3], 2) == 5'h00})
        else $error("sense gain");
    chk_manual_trim: assert property (wr_in && addr_in == 8'h2F && wdata_in[7:3] != 5'h00
        |-> ##2 trim_out == $past(wdata_in[7:3], 2)) else $error("manual trim");
    chk_sw_code: assert property (wr_in && addr_in == 8'h40 && wdata_in[7]
        |-> ##2 reg_code_out == $past(wdata_in[6:3], 2)) else $error("sw code");
    chk_cal_rsvd: assert property (rd_in && addr_in == 8'h30 |=> !rdata_out[0])
        else $error("reserved bit");
    cover property (peak_clear_in ##1 rd_in);
    cover property (wr_in && addr_in == 8'h2F && wdata_in[7:3] == 5'h00);
    cover property (wr_in && addr_in == 8'h40 && wdata_in[7]);
endmodule

bind frr_readout_regs frr_readout_checker #(.CODE_W(CODE_W), .TRIM_W(TRIM_W)) frr_checker_inst (.*);

// ---- sim/frr_readout_regs_tb.sv ----
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module frr_readout_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, adjust_done_in = 0, ilim_in = 0, rx_start_in = 0;
    logic peak_clear_in = 0, cal_done_in = 0, cal_fail_in = 0, auto_cal_out, irq_out;
    logic [7:0] addr_in = 0, wdata_in = 0, rdata_out, d, w, e [5];
    logic [3:0] adjust_code_in = 0, amp_level_in = 0, phase_level_in = 0, reg_code_out;
    logic [3:0] amp_gain_cut_in = 0, phase_gain_cut_in = 0;
    logic [4:0] auto_trim_in = 0, trim_out, t;
    logic [2:0] sense_gain_out;
    logic [31:0] s = 32'hABE97305;
    int fail_count = 0, tests_run = 0, cyc = 0;
    frr_readout_regs frr_readout_regs_inst (.*);
    initial forever #4 clock_in = ~clock_in;
    ////////////////////////////////////////////////////////////
    function automatic [31:0] lfsr(input [31:0] v);
        lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic [3:0] mx(input [3:0] a, b);
        mx = a > b ? a : b;
    endfunction
    task automatic complete_run;
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic tick;
        @(posedge clock_in);
        #1;
    endtask
    task automatic wr(input [7:0] a, input [7:0] v);
        @(posedge clock_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1;
        @(posedge clock_in);
        wr_in <= 0;
    endtask
    // Also ends a pending clear pulse, so a read can follow it directly
    task automatic rd(input [7:0] a);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1;
        peak_clear_in <= 0;
        @(posedge clock_in);
        rd_in <= 0;
        #1 d = rdata_out;
    endtask
    always @(posedge clock_in) begin
        cyc++;
        if (cyc > 3000) begin
            fail_count++;
            complete_run;
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock_in);
        rst_in <= 0;
        // Gain codes walk through all values; pass 1 forces automatic trim
        for (int i = 0; i < 8; i++) begin
            repeat (32) s = lfsr(s);
            w = {i == 1 ? 5'h00 : s[31:27], i[2:0]};
            wr(8'h2F, w);
            tick;
            `CHK({sense_gain_out, auto_cal_out}, {w[2:0], w[7:3] == 5'h00})
            @(posedge clock_in);
            {adjust_code_in, ilim_in, amp_gain_cut_in, phase_gain_cut_in, auto_trim_in, cal_fail_in} <= s[18:0];
            {adjust_done_in, cal_done_in, peak_clear_in, rx_start_in} <= {2'b11, i[0], !i[0]};
            @(posedge clock_in);
            {adjust_done_in, cal_done_in, peak_clear_in, rx_start_in} <= 4'h0;
            {amp_level_in, phase_level_in} <= s[26:19];
            @(posedge clock_in);
            {amp_level_in, phase_level_in} <= {s[30:27], s[3:0]};
            @(posedge clock_in);
            {amp_level_in, phase_level_in} <= 8'h00;
            t = w[7:3] != 5'h00 ? w[7:3] : s[5:1];
            e = '{{s[18:15], 3'h0, s[14]}, {mx(s[26:23], s[30:27]), mx(s[22:19], s[3:0])}, s[13:6], w,
                {t, 1'b1, s[0], 1'b0}};
            wr(i[0] ? 8'h2D : 8'h30, s[7:0]);
            for (int k = 0; k < 5; k++) begin
                rd(8'(8'h2C + k));
                `CHK(d, e[k])
            end
            `CHK({reg_code_out, trim_out}, {s[18:15], t})
        end
        `CHK(irq_out, 1'b0)
        wr(8'h42, 8'h0F);
        tick;
        `CHK(irq_out, 1'b1)
        wr(8'h41, 8'h0F);
        tick;
        `CHK(irq_out, 1'b0)
        wr(8'h42, 8'h01);
        @(posedge clock_in) cal_done_in <= 1;
        @(posedge clock_in) cal_done_in <= 0;
        tick;
        `CHK(irq_out, 1'b1)
        rd(8'h41);
        `CHK(d, {6'h00, cal_fail_in, 1'b1})
        wr(8'h40, 8'hD0);
        tick;
        `CHK(reg_code_out, 4'hA)
        @(posedge clock_in) peak_clear_in <= 1;
        rd(8'h2D);
        `CHK(d, 8'h00)
        rd(8'h55);
        `CHK(d, 8'h00)
        complete_run;
    end
endmodule
